// *** uem_cfg.svh ***
`ifndef UEM_CFG_SVH
`define UEM_CFG_SVH

// register byte offsets in the extended capability space
`define UEM_OFF_STATUS 12'h104
`define UEM_OFF_MASK 12'h108
`define UEM_OFF_SEVERITY 12'h10C
`define UEM_OFF_AERCTL 12'h118
`define UEM_OFF_IRQ_STATUS 12'h200
`define UEM_OFF_IRQ_CLEAR 12'h204
`define UEM_OFF_IRQ_ENABLE 12'h208

// implemented error classes: bits 0, 4, 12..21
`define UEM_IMPL_BITS 32'h003F_F011
`define UEM_MASK_RESET 32'h0000_0000
// fatal at reset: training, dl protocol, flow control, overflow, malformed
`define UEM_SEV_RESET 32'h0006_2011
`define UEM_STATUS_RESET 32'h0000_0000

// first error pointer field in the aer control word
`define UEM_FEP_LSB 0
`define UEM_FEP_W 5

// interrupt status bit positions
`define UEM_IRQ_FATAL 0
`define UEM_IRQ_NONFATAL 1
`define UEM_IRQ_MASKED 2
`define UEM_IRQ_W 3

// bus answer latency in cycles after the request is seen
`define UEM_BUS_LATENCY 1

`endif

// *** uem_pkg.sv ***
package uem_pkg;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    UEM_BUS_IDLE = 2'b01,
    UEM_BUS_DONE = 2'b10
  } uem_bus_state_t;

  // error report toward the transaction layer
  typedef struct packed {
    logic headerCapture;
    logic fatalMsg;
    logic nonFatalMsg;
    logic [4:0] errorClass;
  } uem_report_t;

endpackage : uem_pkg

// *** uem_error_mask_severity.sv ***
`include "uem_cfg.svh"

// Summary of operation
// RULE_01: training error masked means no header capture and no message.
// RULE_02: data link protocol error masked means no header capture, no message.
// RULE_03: poisoned packet masked means no header capture and no message.
// RULE_04: flow control protocol error masked means no capture, no message.
// RULE_05: completion timeout masked means no header capture and no message.
// RULE_06: completer abort masked means no header capture and no message.
// RULE_07: unexpected completion masked means no header capture and no message.
// RULE_08: receiver overflow masked means no header capture and no message.
// RULE_09: malformed packet masked means no header capture and no message.
// RULE_10: end-to-end crc error masked means no capture and no message.
// RULE_11: unsupported request masked means no header capture and no message.
// RULE_12: severity one is fatal; five link classes reset to fatal.
// RULE_13: the other seven severity bits reset to non-fatal.
// RULE_14: each event sets its sticky status bit; software writes one to clear.
// RULE_15: five-bit pointer holds the bit of the first reported error.
// RULE_16: unmasked error sends fatal message if severity set, else non-fatal.
// RULE_17: mask and severity writable and sticky; reserved bits read zero.
module uem_error_mask_severity #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic porReset_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [31:0] errEvent,
  output uem_pkg::uem_report_t report,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // offsets reach 0x208, so narrower addresses cannot decode the map
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 10 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // expand byte enables to a bit mask
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : laneMask

  // lowest set bit position, the tie-break when several classes hit at once
  function automatic logic [4:0] firstBit(input logic [31:0] v);
    logic [4:0] idx;
    idx = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[4:0];
      end
    end
    return idx;
  endfunction : firstBit

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  uem_pkg::uem_bus_state_t busState;
  logic [31:0] errStatus;
  logic [31:0] errMask;
  logic [31:0] errSeverity;
  logic [4:0] firstErrPtr;
  logic fepValid;
  logic [`UEM_IRQ_W-1:0] irqStatus;
  logic [`UEM_IRQ_W-1:0] irqEnable;
  logic busReq;
  logic busTake;
  logic wrTake;
  logic [31:0] wrBits;
  logic [31:0] hitEvents;
  logic [31:0] unmasked;
  logic [31:0] maskedHits;
  logic [31:0] next_errStatus;
  logic [`UEM_IRQ_W-1:0] irqEvents;
  logic [4:0] firstUnmasked;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave handshake

  // every access answers one cycle after it is seen
  assign busReq = read | write;
  assign waitrequest = busReq & (busState != uem_pkg::UEM_BUS_DONE);
  assign busTake = busReq & (busState == uem_pkg::UEM_BUS_DONE);
  assign wrTake = write & busTake;
  assign wrBits = writedata & laneMask(byteenable);

  // two-state sequencer; done lasts one cycle so back-to-back works
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busState <= uem_pkg::UEM_BUS_IDLE;
    end else begin
      case (busState)
        uem_pkg::UEM_BUS_IDLE: begin
          if (busReq) begin
            busState <= uem_pkg::UEM_BUS_DONE;
          end
        end
        uem_pkg::UEM_BUS_DONE: begin
          busState <= uem_pkg::UEM_BUS_IDLE;
        end
        default: begin
          busState <= uem_pkg::UEM_BUS_IDLE;
        end
      endcase
    end
  end

  // read data staged while waitrequest is high; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && busState == uem_pkg::UEM_BUS_IDLE) begin
      case (32'(address))
        32'(`UEM_OFF_STATUS): readdata <= errStatus;
        32'(`UEM_OFF_MASK): readdata <= errMask;
        32'(`UEM_OFF_SEVERITY): readdata <= errSeverity;
        32'(`UEM_OFF_AERCTL): readdata <= {27'h000_0000, firstErrPtr};
        32'(`UEM_OFF_IRQ_STATUS): readdata <= {29'h0000_0000, irqStatus};
        32'(`UEM_OFF_IRQ_ENABLE): readdata <= {29'h0000_0000, irqEnable};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask and severity, sticky: only the power-on reset touches them

  // unimplemented positions never store, so they read zero
  always_ff @(posedge clk) begin
    if (!porReset_n) begin
      errMask <= `UEM_MASK_RESET;
    end else if (wrTake && address == ADDR_W'(`UEM_OFF_MASK)) begin
      errMask <= (errMask & ~laneMask(byteenable)) | (wrBits & `UEM_IMPL_BITS); // RULE_17
    end
  end

  // one selects fatal reporting for the class
  always_ff @(posedge clk) begin
    if (!porReset_n) begin
      errSeverity <= `UEM_SEV_RESET; // RULE_12 RULE_13
    end else if (wrTake && address == ADDR_W'(`UEM_OFF_SEVERITY)) begin
      errSeverity <= (errSeverity & ~laneMask(byteenable)) | (wrBits & `UEM_IMPL_BITS); // RULE_17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error status and first error pointer

  // events on unimplemented positions are dropped here
  assign hitEvents = errEvent & `UEM_IMPL_BITS;
  assign unmasked = hitEvents & ~errMask; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
  assign maskedHits = hitEvents & errMask; // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11

  // one priority pick shared by the pointer and the report
  assign firstUnmasked = firstBit(unmasked);

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_errStatus = errStatus;
    if (wrTake && address == ADDR_W'(`UEM_OFF_STATUS)) begin
      next_errStatus = errStatus & ~wrBits;
    end
    next_errStatus = next_errStatus | hitEvents; // RULE_14
  end

  // status keeps its value across the ordinary reset
  always_ff @(posedge clk) begin
    if (!porReset_n) begin
      errStatus <= `UEM_STATUS_RESET;
    end else begin
      errStatus <= next_errStatus;
    end
  end

  // pointer rearms once software clears the bit it points at
  always_ff @(posedge clk) begin
    if (!porReset_n) begin
      firstErrPtr <= 5'h00;
      fepValid <= 1'b0;
    end else if (!fepValid && unmasked != 32'h0000_0000) begin
      firstErrPtr <= firstUnmasked; // RULE_15
      fepValid <= 1'b1;
    end else if (fepValid && !next_errStatus[firstErrPtr]) begin
      // an error arriving in the clearing cycle takes the freed pointer
      fepValid <= unmasked != 32'h0000_0000;
      if (unmasked != 32'h0000_0000) begin
        firstErrPtr <= firstUnmasked; // RULE_15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // report toward the transaction layer

  // registered pulses, one cycle after the event strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      report <= '0;
    end else begin
      report.headerCapture <= unmasked != 32'h0000_0000;
      report.fatalMsg <= (unmasked & errSeverity) != 32'h0000_0000; // RULE_16
      report.nonFatalMsg <= (unmasked & ~errSeverity) != 32'h0000_0000; // RULE_16
      report.errorClass <= firstUnmasked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable

  assign irqEvents[`UEM_IRQ_FATAL] = report.fatalMsg;
  assign irqEvents[`UEM_IRQ_NONFATAL] = report.nonFatalMsg;
  assign irqEvents[`UEM_IRQ_MASKED] = maskedHits != 32'h0000_0000;

  // clear register is write-only; a new event beats its clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqStatus <= '0;
    end else if (wrTake && address == ADDR_W'(`UEM_OFF_IRQ_CLEAR)) begin
      irqStatus <= (irqStatus & ~wrBits[`UEM_IRQ_W-1:0]) | irqEvents;
    end else begin
      irqStatus <= irqStatus | irqEvents;
    end
  end

  // enable register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irqEnable <= '0;
    end else if (wrTake && address == ADDR_W'(`UEM_OFF_IRQ_ENABLE) && byteenable[0]) begin
      // all three enables sit in the lowest byte lane
      irqEnable <= wrBits[`UEM_IRQ_W-1:0];
    end
  end

  assign irq = (irqStatus & irqEnable) != '0;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n || !porReset_n);

  a_mask_blocks_report: assert property ( // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 RULE_10 RULE_11
    (errEvent & `UEM_IMPL_BITS & ~errMask) == 32'h0000_0000
    |=> !report.headerCapture && !report.fatalMsg && !report.nonFatalMsg)
    else $error("masked error produced a report");

  a_fatal_message: assert property ( // RULE_16
    ((errEvent & `UEM_IMPL_BITS & ~errMask & errSeverity) != 32'h0000_0000)
    |=> report.fatalMsg && report.headerCapture)
    else $error("unmasked fatal error sent no fatal message");

  a_nonfatal_message: assert property ( // RULE_16
    ((errEvent & `UEM_IMPL_BITS & ~errMask) != 32'h0000_0000)
    && ((errEvent & `UEM_IMPL_BITS & ~errMask & errSeverity) == 32'h0000_0000)
    |=> report.nonFatalMsg && !report.fatalMsg)
    else $error("non-fatal error message wrong");

  a_status_sets: assert property ( // RULE_14
    hitEvents != 32'h0000_0000
    |=> (errStatus & $past(hitEvents)) == $past(hitEvents))
    else $error("error event did not set status");

  a_fep_capture: assert property ( // RULE_15
    !fepValid && unmasked != 32'h0000_0000
    |=> fepValid && firstErrPtr == $past(firstUnmasked))
    else $error("first error pointer not captured");

  a_fep_holds: assert property ( // RULE_15
    fepValid && errStatus[firstErrPtr] && !wrTake |=> $stable(firstErrPtr))
    else $error("first error pointer moved while valid");

  a_reserved_zero: assert property ( // RULE_17
    (errMask & ~`UEM_IMPL_BITS) == 32'h0000_0000
    && (errSeverity & ~`UEM_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved mask or severity bit set");

  // own disable: the ordinary reset is exactly what this one watches
  a_sticky_survives: assert property (@(posedge clk) disable iff (!porReset_n) // RULE_17
    !reset_n |=> $stable(errMask) && $stable(errSeverity))
    else $error("sticky field lost on ordinary reset");

  a_sev_reset: assert property (@(posedge clk) // RULE_12 RULE_13
    $rose(porReset_n) |-> errSeverity == `UEM_SEV_RESET)
    else $error("severity reset value wrong");

  a_bus_answer: assert property (
    busReq && waitrequest |=> !waitrequest ##1 (!busReq || waitrequest))
    else $error("bus answer latency wrong");

  a_mask_reset: assert property ( // RULE_17 RULE_14
    $rose(porReset_n) |-> errMask == `UEM_MASK_RESET && errStatus == `UEM_STATUS_RESET)
    else $error("mask or status reset value wrong");

  a_mask_write: assert property ( // RULE_17
    wrTake && address == ADDR_W'(`UEM_OFF_MASK) && byteenable == 4'hF
    |=> errMask == ($past(writedata) & `UEM_IMPL_BITS))
    else $error("mask write did not store implemented bits");

  a_status_clear: assert property ( // RULE_14
    wrTake && address == ADDR_W'(`UEM_OFF_STATUS)
    |=> (errStatus & $past(wrBits) & ~$past(hitEvents)) == 32'h0000_0000)
    else $error("write one did not clear status");

  a_status_reserved: assert property ( // RULE_14
    (errStatus & ~`UEM_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved status bit set");

  a_header_capture: assert property ( // RULE_16
    report.headerCapture == (report.fatalMsg || report.nonFatalMsg))
    else $error("header capture and message disagree");

  a_error_class: assert property ( // RULE_16
    unmasked != 32'h0000_0000 |=> report.errorClass == $past(firstUnmasked))
    else $error("reported error class wrong");

  a_irq_fatal_set: assert property ( // RULE_16
    report.fatalMsg |=> irqStatus[`UEM_IRQ_FATAL])
    else $error("fatal message did not set interrupt status");

  a_irq_masked_set: assert property ( // RULE_14
    maskedHits != 32'h0000_0000 |=> irqStatus[`UEM_IRQ_MASKED])
    else $error("masked error did not set interrupt status");

endmodule : uem_error_mask_severity

// *** uem_rc_model.sv ***
module uem_rc_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire uem_pkg::uem_report_t report,
  output logic msgValid,
  output uem_pkg::uem_report_t msg
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // receiving end: latches every message the port sends upstream
  // a masked class must never reach here, so any stray pulse is visible
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      msgValid <= 1'b0;
      msg <= '0;
    end else begin
      msgValid <= report.headerCapture | report.fatalMsg | report.nonFatalMsg;
      msg <= report;
    end
  end
endmodule : uem_rc_model

// *** tb_uncorrectable_error_mask_severity.sv ***
`include "uem_cfg.svh"

module tb_uncorrectable_error_mask_severity;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset_n, porReset_n, read, write, waitrequest, irq, msgValid;
  logic [11:0] address;
  logic [3:0] be;
  logic [31:0] writedata, readdata, errEvent, s;
  uem_pkg::uem_report_t report, msg;
  int err_count, compares, seed, cls[12];
  logic [31:0] rq[$], eq[$];

  uem_error_mask_severity dut_u (.clk(clk), .reset_n(reset_n), .porReset_n(porReset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .errEvent(errEvent), .report(report), .irq(irq));
  uem_rc_model rc_u (.clk(clk), .reset_n(reset_n), .report(report), .msgValid(msgValid),
    .msg(msg));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    if (rq.size() != 0 || eq.size() != 0) err_count++;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // request held until the edge that sees waitrequest low, then released
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk iff waitrequest === 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // one-cycle event pulse; hit notes the message the far end should get
  task automatic ev(input logic [31:0] b, input logic hit, input logic f, input logic n,
      input int c);
    if (hit) eq.push_back({24'h00_0000, 1'b1, f, n, c[4:0]});
    @(posedge clk);
    errEvent <= b;
    @(posedge clk);
    errEvent <= 32'h0000_0000;
  endtask : ev

  ////////////////////////////////////////////////////////////////////////////
  // watcher: read data at the accepting edge, messages as the far end sees them
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) chk("readdata", rq.size() ? rq.pop_front() : 'x, readdata);
    if (msgValid) chk("report", eq.size() ? eq.pop_front() : 32'h0000_0000, {24'h00_0000, msg});
  end

  // watchdog: whole sequence is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 47423;
    cls = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
    {reset_n, porReset_n, read, write} = 4'h0;
    address = 12'h000;
    be = 4'hF;
    writedata = 32'h0000_0000;
    errEvent = 32'h0000_0000;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    porReset_n <= 1'b1;
    rd(`UEM_OFF_MASK, 32'h0000_0000);
    rd(`UEM_OFF_SEVERITY, 32'h0006_2011);
    rd(12'h300, 32'h0000_0000);
    bus(1'b1, `UEM_OFF_MASK, 32'hFFFF_FFFF);
    rd(`UEM_OFF_MASK, 32'h003F_F011);
    s = $random(seed);
    bus(1'b1, `UEM_OFF_SEVERITY, s);
    rd(`UEM_OFF_SEVERITY, s & 32'h003F_F011);
    // sticky mask rides through an ordinary reset; only the mask is read back
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    rd(`UEM_OFF_MASK, 32'h003F_F011);
    // only byte lane 2 written: classes 16..21 unmasked, the rest kept
    be <= 4'h4;
    bus(1'b1, `UEM_OFF_MASK, 32'h0000_0000);
    be <= 4'hF;
    rd(`UEM_OFF_MASK, 32'h0000_F011);
    // every class unmasked then masked
    foreach (cls[i]) begin
      bus(1'b1, `UEM_OFF_MASK, 32'h0000_0000);
      ev(32'h1 << cls[i], 1'b1, s[cls[i]], !s[cls[i]], cls[i]);
      rd(`UEM_OFF_STATUS, 32'h1 << cls[i]);
      rd(`UEM_OFF_AERCTL, cls[i]);
      bus(1'b1, `UEM_OFF_STATUS, 32'h1 << cls[i]);
      rd(`UEM_OFF_STATUS, 32'h0000_0000);
      bus(1'b1, `UEM_OFF_MASK, 32'h1 << cls[i]);
      ev(32'h1 << cls[i], 1'b0, 1'b0, 1'b0, 0);
      rd(`UEM_OFF_STATUS, 32'h1 << cls[i]);
      bus(1'b1, `UEM_OFF_STATUS, 32'h1 << cls[i]);
    end
    // interrupt: raise, hold off by enable, clear
    bus(1'b1, `UEM_OFF_IRQ_CLEAR, 32'h0000_0007);
    bus(1'b1, `UEM_OFF_IRQ_ENABLE, 32'h0000_0001);
    bus(1'b1, `UEM_OFF_MASK, 32'h0000_0000);
    bus(1'b1, `UEM_OFF_SEVERITY, 32'h0000_0000);
    ev(32'h0000_4000, 1'b1, 1'b0, 1'b1, 14);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(`UEM_OFF_IRQ_STATUS, 32'h0000_0002);
    bus(1'b1, `UEM_OFF_IRQ_ENABLE, 32'h0000_0002);
    @(negedge clk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    bus(1'b1, `UEM_OFF_IRQ_CLEAR, 32'h0000_0002);
    @(negedge clk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(`UEM_OFF_IRQ_CLEAR, 32'h0000_0000);
    // two classes at once, one fatal one not
    bus(1'b1, `UEM_OFF_STATUS, 32'hFFFF_FFFF);
    bus(1'b1, `UEM_OFF_SEVERITY, 32'h0000_0001);
    ev(32'h0000_4001, 1'b1, 1'b1, 1'b1, 0);
    rd(`UEM_OFF_STATUS, 32'h0000_4001);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : tb_uncorrectable_error_mask_severity
